/* File: logic/psrc_pkg.sv */
// Purpose: shared constants and types of the sleep and reset control block
// Assumes: 100 MHz system clock, AXI4-Lite register access
// Notes: all register offsets are byte addresses of aligned words
package psrc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DEBOUNCE_MS = 16;
  localparam int unsigned OVERRIDE_S_DEF = 4;
  localparam int unsigned WIDTH_UNIT_US = 1000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned SECOND_CYC = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned WIDTH_UNIT_CYC = WIDTH_UNIT_US * 1000 / CLK_PERIOD_NS;
  localparam logic [4:0] RESET_HOLD_CYC = 5'h10;

  localparam int DB_W = 21;
  localparam int SEC_W = 27;
  localparam int UNIT_W = 17;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CMD_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] EVENT_OFS = 8'h0c;

  localparam int CTRL_SMI_SEL = 0;
  localparam int CTRL_DEEP_EN = 1;
  localparam int CTRL_LAN_OFF_OK = 2;
  localparam int CTRL_VWIRE_EN = 3;
  localparam int CTRL_OVR_LSB = 4;
  localparam int CTRL_MINW_LSB = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0040;

  localparam logic [2:0] CMD_SLEEP = 3'h1;
  localparam logic [2:0] CMD_HIBERNATE = 3'h2;
  localparam logic [2:0] CMD_SOFT_OFF = 3'h3;
  localparam logic [2:0] CMD_COLD_RESET = 3'h4;
  localparam logic [2:0] CMD_WARM_RESET = 3'h5;
  localparam logic [2:0] CMD_GLOBAL_RESET = 3'h6;

  localparam int EV_BUTTON = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_OVERRIDE = 2;
  localparam int EV_N_A = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_WORKING, ST_SLEEP, ST_HIBERNATE, ST_SOFT_OFF, ST_DEEP_OFF, ST_RESET
  } pwr_state_t;

  typedef struct packed {
    logic pg_s1;
    logic pg_s2;
    logic [DB_W-1:0] db_cnt;
    logic btn_db;
    logic [SEC_W-1:0] ovr_sub;
    logic [3:0] ovr_sec;
    logic ovr_done;
    logic via_ovr;
    pwr_state_t state;
    logic [4:0] rst_cnt;
    logic [UNIT_W-1:0] unit_cnt;
    logic [7:0] ma_cnt;
    logic ma_sleep;
    logic lan_sleep;
    logic phy_req;
    logic plat_rst_n;
    logic ma_pin_n;
    logic ma_vw;
    logic lan_n;
    logic deep_off;
    logic smi;
    logic sci;
    logic wake;
    logic pullup_en;
    logic [15:0] ctrl;
    logic [3:0] events;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;
endpackage

/* File: logic/platform_sleep_reset_control.sv */
// Purpose: platform reset, power button, sleep and lan power pin control
// Assumes: pins other than core_power_good are synchronous to clk_sys
// Notes: registers over AXI4-Lite; clk_en low freezes every flip-flop
`timescale 1ns/100ps

// Behaviour
// - platform reset asserted whenever core power good is low
// - core power good passes a two-stage synchroniser before use
// - platform reset low in sleep states and during any reset
// - platform reset released on wake and when a reset completes
// - button press while working raises smi or sci event
// - button press while sleeping raises a wake event
// - button held past programmed seconds forces soft-off
// - override also acts from hibernate
// - button debounced over 16 ms, internal pull-up enabled
// - after override soft-off, go deep off when enabled and allowed
// - primary-well reset low holds the block's logic in reset
// - management sleep asserted when engine is off or power gated
// - management sleep held for a programmable minimum width
// - management sleep on pin or as virtual wire
// - lan sleep asserted only when lan power may be removed
// - lan sleep deasserted when working or management sleep deasserted
// - lan phy power request pulses when lan power must return
// - low n_a input counts as a wake indication
module platform_sleep_reset_control #(
  parameter logic [psrc_pkg::DB_W-1:0] DEBOUNCE_CYCLES =
    psrc_pkg::DB_W'(psrc_pkg::DEBOUNCE_CYC),
  parameter logic [psrc_pkg::SEC_W-1:0] SECOND_CYCLES =
    psrc_pkg::SEC_W'(psrc_pkg::SECOND_CYC),
  parameter logic [psrc_pkg::UNIT_W-1:0] WIDTH_UNIT_CYCLES =
    psrc_pkg::UNIT_W'(psrc_pkg::WIDTH_UNIT_CYC)
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic core_power_good,
  input wire logic primary_well_reset_n,
  input wire logic power_button_n,
  input wire logic lan_wakeup_req_n,
  input wire logic mgmt_engine_off,
  input wire logic mgmt_engine_power_gated,
  input wire logic deep_sleep_allowed,
  output logic platform_reset_n,
  output logic mgmt_subsys_sleep_n,
  output logic mgmt_sleep_vwire,
  output logic lan_subsys_sleep_n,
  output logic lan_phy_power_request,
  output logic deep_sleep_well_off,
  output logic system_mgmt_irq,
  output logic sci_event,
  output logic wake_event,
  output logic power_button_pullup_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam psrc_pkg::state_t RESET_STATE = '{
    state: psrc_pkg::ST_RESET, rst_cnt: psrc_pkg::RESET_HOLD_CYC,
    btn_db: 1'b1, pullup_en: 1'b1, ctrl: psrc_pkg::CTRL_RESET,
    awready: 1'b1, wready: 1'b1, arready: 1'b1, ma_pin_n: 1'b1,
    lan_n: 1'b1, default: '0
  };

  psrc_pkg::state_t s_r;
  psrc_pkg::state_t s_nxt;

  always_comb begin
    logic press, ovr_fire, wake_req, ma_req, cmd_valid;
    logic [3:0] ev_set, ev_clr, ovr_limit;
    logic [2:0] cmd;
    logic [31:0] merged;
    press = 1'b0;
    ovr_fire = 1'b0;
    wake_req = 1'b0;
    ma_req = 1'b0;
    ev_set = 4'h0;
    ev_clr = 4'h0;
    cmd = 3'h0;
    cmd_valid = 1'b0;
    merged = 32'h0;
    ovr_limit = 4'h0;
    s_nxt = s_r;
    s_nxt.smi = 1'b0;
    s_nxt.sci = 1'b0;
    s_nxt.wake = 1'b0;
    s_nxt.phy_req = 1'b0;

    s_nxt.pg_s1 = core_power_good;
    s_nxt.pg_s2 = s_r.pg_s1;

    if (power_button_n != s_r.btn_db) begin
      if (s_r.db_cnt >= DEBOUNCE_CYCLES - psrc_pkg::DB_W'(1)) begin
        s_nxt.btn_db = power_button_n;
        s_nxt.db_cnt = '0;
        press = !power_button_n;
      end else begin
        s_nxt.db_cnt = s_r.db_cnt + psrc_pkg::DB_W'(1);
      end
    end else begin
      s_nxt.db_cnt = '0;
    end

    ovr_limit = s_r.ctrl[psrc_pkg::CTRL_OVR_LSB +: 4];
    if (ovr_limit == 4'h0) begin
      ovr_limit = 4'h1;
    end
    if (s_r.btn_db) begin
      s_nxt.ovr_sub = '0;
      s_nxt.ovr_sec = 4'h0;
      s_nxt.ovr_done = 1'b0;
    end else if (!s_r.ovr_done) begin
      if (s_r.ovr_sub >= SECOND_CYCLES - psrc_pkg::SEC_W'(1)) begin
        s_nxt.ovr_sub = '0;
        s_nxt.ovr_sec = s_r.ovr_sec + 4'h1;
        if (s_r.ovr_sec + 4'h1 >= ovr_limit) begin
          ovr_fire = 1'b1;
          s_nxt.ovr_done = 1'b1;
        end
      end else begin
        s_nxt.ovr_sub = s_r.ovr_sub + psrc_pkg::SEC_W'(1);
      end
    end

    // write channel: address and data taken in either order
    if (s_r.awready && s_axi_awvalid) begin
      s_nxt.awready = 1'b0;
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_r.wready && s_axi_wvalid) begin
      s_nxt.wready = 1'b0;
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = psrc_pkg::RESP_OKAY;
      for (int i = 0; i < 4; i++) begin
        merged[8*i +: 8] = s_r.wstrb[i] ? s_r.wdata[8*i +: 8] : 8'h00;
      end
      unique case (s_r.awaddr)
        psrc_pkg::CTRL_OFS: begin
          for (int i = 0; i < 2; i++) begin
            if (s_r.wstrb[i]) begin
              s_nxt.ctrl[8*i +: 8] = s_r.wdata[8*i +: 8];
            end
          end
        end
        psrc_pkg::CMD_OFS: begin
          cmd = merged[2:0];
          cmd_valid = s_r.wstrb[0];
        end
        psrc_pkg::EVENT_OFS: begin
          ev_clr = merged[3:0];
        end
        psrc_pkg::STATUS_OFS: begin
          // read-only: write ignored
        end
        default: begin
          s_nxt.bresp = psrc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end

    // read channel
    if (s_r.arready && s_axi_arvalid) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = psrc_pkg::RESP_OKAY;
      s_nxt.rdata = 32'h0;
      unique case (s_axi_araddr)
        psrc_pkg::CTRL_OFS: s_nxt.rdata[15:0] = s_r.ctrl;
        psrc_pkg::CMD_OFS: s_nxt.rdata = 32'h0;
        psrc_pkg::STATUS_OFS: begin
          s_nxt.rdata[2:0] = s_r.state;
          s_nxt.rdata[3] = s_r.pg_s2;
          s_nxt.rdata[4] = s_r.btn_db;
          s_nxt.rdata[5] = s_r.ma_sleep;
          s_nxt.rdata[6] = s_r.lan_sleep;
          s_nxt.rdata[7] = s_r.via_ovr;
        end
        psrc_pkg::EVENT_OFS: s_nxt.rdata[3:0] = s_r.events;
        default: s_nxt.rresp = psrc_pkg::RESP_SLVERR;
      endcase
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end

    wake_req = press || !lan_wakeup_req_n;
    if (!lan_wakeup_req_n && s_r.state != psrc_pkg::ST_WORKING) begin
      ev_set[psrc_pkg::EV_N_A] = 1'b1;
    end

    unique case (s_r.state)
      psrc_pkg::ST_WORKING: begin
        // request sleep via smi or sci
        if (press) begin
          ev_set[psrc_pkg::EV_BUTTON] = 1'b1;
          if (s_r.ctrl[psrc_pkg::CTRL_SMI_SEL]) begin
            s_nxt.smi = 1'b1;
          end else begin
            s_nxt.sci = 1'b1;
          end
        end
        if (cmd_valid) begin
          unique case (cmd)
            psrc_pkg::CMD_SLEEP: s_nxt.state = psrc_pkg::ST_SLEEP;
            psrc_pkg::CMD_HIBERNATE: s_nxt.state = psrc_pkg::ST_HIBERNATE;
            psrc_pkg::CMD_SOFT_OFF: s_nxt.state = psrc_pkg::ST_SOFT_OFF;
            psrc_pkg::CMD_COLD_RESET, psrc_pkg::CMD_WARM_RESET,
            psrc_pkg::CMD_GLOBAL_RESET: begin
              s_nxt.state = psrc_pkg::ST_RESET;
              s_nxt.rst_cnt = psrc_pkg::RESET_HOLD_CYC;
            end
            default: begin
            end
          endcase
        end
      end
      psrc_pkg::ST_SLEEP, psrc_pkg::ST_HIBERNATE, psrc_pkg::ST_SOFT_OFF,
      psrc_pkg::ST_DEEP_OFF: begin
        if (wake_req) begin
          s_nxt.state = psrc_pkg::ST_WORKING;
          s_nxt.via_ovr = 1'b0;
          s_nxt.wake = 1'b1;
          ev_set[psrc_pkg::EV_WAKE] = 1'b1;
        // override soft-off continues to deep off
        end else if (s_r.state == psrc_pkg::ST_SOFT_OFF && s_r.via_ovr &&
                     s_r.ctrl[psrc_pkg::CTRL_DEEP_EN] && deep_sleep_allowed)
        begin
          s_nxt.state = psrc_pkg::ST_DEEP_OFF;
          s_nxt.via_ovr = 1'b0;
        end
      end
      psrc_pkg::ST_RESET: begin
        if (s_r.rst_cnt == 5'h0) begin
          s_nxt.state = psrc_pkg::ST_WORKING;
        end else begin
          s_nxt.rst_cnt = s_r.rst_cnt - 5'h1;
        end
      end
      default: begin
        s_nxt.state = psrc_pkg::ST_RESET;
        s_nxt.rst_cnt = psrc_pkg::RESET_HOLD_CYC;
      end
    endcase

    // override from any state but soft-off and deep off, including hibernate
    if (ovr_fire && s_r.state != psrc_pkg::ST_SOFT_OFF &&
        s_r.state != psrc_pkg::ST_DEEP_OFF) begin
      s_nxt.state = psrc_pkg::ST_SOFT_OFF;
      s_nxt.via_ovr = 1'b1;
      s_nxt.wake = 1'b0;
      ev_set[psrc_pkg::EV_OVERRIDE] = 1'b1;
    end

    // set wins over a simultaneous write-one clear
    s_nxt.events = (s_r.events & ~ev_clr) | ev_set;

    ma_req = mgmt_engine_off || mgmt_engine_power_gated;
    if (!s_r.ma_sleep) begin
      if (ma_req) begin
        s_nxt.ma_sleep = 1'b1;
        s_nxt.ma_cnt = 8'h0;
        s_nxt.unit_cnt = '0;
      end
    end else if (s_r.ma_cnt < s_r.ctrl[psrc_pkg::CTRL_MINW_LSB +: 8]) begin
      if (s_r.unit_cnt >= WIDTH_UNIT_CYCLES - psrc_pkg::UNIT_W'(1)) begin
        s_nxt.unit_cnt = '0;
        s_nxt.ma_cnt = s_r.ma_cnt + 8'h1;
      end else begin
        s_nxt.unit_cnt = s_r.unit_cnt + psrc_pkg::UNIT_W'(1);
      end
    end else if (!ma_req) begin
      s_nxt.ma_sleep = 1'b0;
    end

    // lan power off only when allowed and no wake pending
    // derived from next values so lan never lags management sleep
    s_nxt.lan_sleep = s_nxt.ma_sleep &&
                      s_nxt.state != psrc_pkg::ST_WORKING &&
                      s_r.ctrl[psrc_pkg::CTRL_LAN_OFF_OK] &&
                      lan_wakeup_req_n;
    // request power back when lan sleep drops
    s_nxt.phy_req = s_r.lan_sleep && !s_nxt.lan_sleep;
    // pin or virtual wire, registered so pins never glitch
    s_nxt.ma_vw = s_nxt.ma_sleep && s_nxt.ctrl[psrc_pkg::CTRL_VWIRE_EN];
    s_nxt.ma_pin_n = !(s_nxt.ma_sleep && !s_nxt.ma_vw);
    s_nxt.lan_n = !s_nxt.lan_sleep;
    s_nxt.deep_off = s_nxt.state == psrc_pkg::ST_DEEP_OFF;

    // reset low outside the working state
    s_nxt.plat_rst_n = s_r.pg_s2 && s_nxt.state == psrc_pkg::ST_WORKING;

    // primary-well reset holds everything but the synchroniser
    if (!primary_well_reset_n) begin
      s_nxt = RESET_STATE;
      s_nxt.pg_s1 = core_power_good;
      s_nxt.pg_s2 = s_r.pg_s1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= RESET_STATE;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign platform_reset_n = s_r.plat_rst_n;
  assign mgmt_subsys_sleep_n = s_r.ma_pin_n;
  assign mgmt_sleep_vwire = s_r.ma_vw;
  assign lan_subsys_sleep_n = s_r.lan_n;
  assign lan_phy_power_request = s_r.phy_req;
  assign deep_sleep_well_off = s_r.deep_off;
  assign system_mgmt_irq = s_r.smi;
  assign sci_event = s_r.sci;
  assign wake_event = s_r.wake;
  assign power_button_pullup_en = s_r.pullup_en;
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rvalid;

endmodule

/* File: test/psrc_monitor.sv */
// Purpose: port assertions for the sleep and reset block
// Assumes: clk_en held high by the bench
// Notes: bound to every instance of the block
`timescale 1ns/100ps
module psrc_monitor (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic core_power_good,
  input wire logic primary_well_reset_n,
  input wire logic power_button_n,
  input wire logic deep_sleep_allowed,
  input wire logic platform_reset_n,
  input wire logic mgmt_subsys_sleep_n,
  input wire logic mgmt_sleep_vwire,
  input wire logic lan_subsys_sleep_n,
  input wire logic lan_phy_power_request,
  input wire logic deep_sleep_well_off,
  input wire logic system_mgmt_irq,
  input wire logic sci_event,
  input wire logic power_button_pullup_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_pg_low;
    !core_power_good [*3] |=> !platform_reset_n; endproperty
  a_pg_low: assert property (p_pg_low) else $error("reset not held");
  property p_pg_sync;
    $rose(platform_reset_n) |-> $past(core_power_good, 3); endproperty
  a_pg_sync: assert property (p_pg_sync) else $error("early release");
  property p_deep_rst;
    deep_sleep_well_off |-> !platform_reset_n; endproperty
  a_deep_rst: assert property (p_deep_rst) else $error("reset up");
  // raw button must have been low two and eight cycles before the event, and smi and sci never both
  property p_btn_ev;
    (sci_event || system_mgmt_irq) |-> !(sci_event && system_mgmt_irq)
      && $past(!power_button_n, 2) && $past(!power_button_n, 8);
  endproperty
  a_btn_ev: assert property (p_btn_ev) else $error("bad press event");
  property p_pullup;
    power_button_pullup_en; endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up off");
  property p_deep_in;
    $rose(deep_sleep_well_off) |->
      $past(deep_sleep_allowed) && $past(!power_button_n, 4);
  endproperty
  a_deep_in: assert property (p_deep_in) else $error("bad deep");
  property p_rsm;
    !primary_well_reset_n |=> !platform_reset_n && !sci_event; endproperty
  a_rsm: assert property (p_rsm) else $error("not in reset");
  property p_lan_mgmt;
    !lan_subsys_sleep_n |-> !mgmt_subsys_sleep_n || mgmt_sleep_vwire;
  endproperty
  a_lan_mgmt: assert property (p_lan_mgmt) else $error("lan sleep");
  property p_phy;
    disable iff (!reset_n || !primary_well_reset_n)
    $rose(lan_subsys_sleep_n) |->
      ##[0:1] (lan_phy_power_request ##1 !lan_phy_power_request);
  endproperty
  a_phy: assert property (p_phy) else $error("no phy request");
endmodule

bind platform_sleep_reset_control psrc_monitor u_mon (
  .clk_sys(clk_sys), .reset_n(reset_n), .core_power_good(core_power_good),
  .primary_well_reset_n(primary_well_reset_n),
  .power_button_n(power_button_n), .deep_sleep_allowed(deep_sleep_allowed),
  .platform_reset_n(platform_reset_n),
  .mgmt_subsys_sleep_n(mgmt_subsys_sleep_n),
  .mgmt_sleep_vwire(mgmt_sleep_vwire),
  .lan_subsys_sleep_n(lan_subsys_sleep_n),
  .lan_phy_power_request(lan_phy_power_request),
  .deep_sleep_well_off(deep_sleep_well_off),
  .system_mgmt_irq(system_mgmt_irq), .sci_event(sci_event),
  .power_button_pullup_en(power_button_pullup_en));

/* File: test/board_model.sv */
// Purpose: board, regulator and lan connect device stand-in
// Assumes: bench requests change just after a clock edge
// Notes: released lines return to their pull-up level
`timescale 1ns/100ps
module board_model #(
  parameter int RSM_HOLD = 20
) (
  input wire logic clk_sys,
  input wire logic pg_on,
  input wire logic press,
  input wire logic n_a,
  output logic core_power_good,
  output logic primary_well_reset_n,
  output logic power_button_n,
  output logic lan_wakeup_req_n
);
  int cnt = 0;
  always @(posedge clk_sys) begin
    if (cnt < RSM_HOLD) cnt <= cnt + 1;
    primary_well_reset_n <= (cnt >= RSM_HOLD);
    core_power_good <= pg_on;
    power_button_n <= !press;
    lan_wakeup_req_n <= !n_a;
  end
endmodule

/* File: test/platform_sleep_reset_control_tb.sv */
// Purpose: self-checking bench for the sleep and reset block
// Assumes: short debounce, second and width counts
// Notes: registers reached through small AXI4-Lite tasks
`timescale 1ns/100ps
module platform_sleep_reset_control_tb;
  logic clk_sys = 1'b0;
  logic reset_n, pg_on, press, n_a, eng_off, eng_pg, deep_ok;
  logic pg, rsm_n, btn_n, lwake_n, prst_n, ma_n, vw, lan_n, phy, deep;
  logic smi, sci, wake, pu, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, rd_val;
  logic [3:0] ws;
  logic [1:0] bresp, rresp;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  int seen [4] = '{0, 0, 0, 0};

  always #5 clk_sys = ~clk_sys;

  board_model u_board (.clk_sys(clk_sys), .pg_on(pg_on), .press(press),
    .n_a(n_a), .core_power_good(pg), .primary_well_reset_n(rsm_n),
    .power_button_n(btn_n), .lan_wakeup_req_n(lwake_n));

  platform_sleep_reset_control #(.DEBOUNCE_CYCLES(21'h8),
    .SECOND_CYCLES(27'h14), .WIDTH_UNIT_CYCLES(17'h4)) u_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1),
    .core_power_good(pg), .primary_well_reset_n(rsm_n),
    .power_button_n(btn_n), .lan_wakeup_req_n(lwake_n),
    .mgmt_engine_off(eng_off), .mgmt_engine_power_gated(eng_pg),
    .deep_sleep_allowed(deep_ok), .platform_reset_n(prst_n),
    .mgmt_subsys_sleep_n(ma_n), .mgmt_sleep_vwire(vw),
    .lan_subsys_sleep_n(lan_n), .lan_phy_power_request(phy),
    .deep_sleep_well_off(deep), .system_mgmt_irq(smi), .sci_event(sci),
    .wake_event(wake), .power_button_pullup_en(pu),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr));

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // pulses last one cycle, so they are counted at every edge
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (sci) seen[0] <= seen[0] + 1;
    if (smi) seen[1] <= seen[1] + 1;
    if (wake) seen[2] <= seen[2] + 1;
    if (phy) seen[3] <= seen[3] + 1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = psrc_pkg::RESP_OKAY);
    @(posedge clk_sys);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a,
                    input logic [1:0] er = psrc_pkg::RESP_OKAY);
    @(posedge clk_sys);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    rd_val = rdat;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic cmd(input logic [2:0] c);
    wr(psrc_pkg::CMD_OFS, {29'h0, c});
  endtask

  task automatic state_is(input logic [2:0] s);
    rd(psrc_pkg::STATUS_OFS);
    chk("state", {29'h0, s}, {29'h0, rd_val[2:0]});
  endtask

  task automatic push(input int n);
    @(posedge clk_sys);
    press <= 1'b1;
    repeat (n) @(posedge clk_sys);
    press <= 1'b0;
    // long enough for the release to pass the debounce
    repeat (12) @(posedge clk_sys);
  endtask

  initial begin
    reset_n <= 1'b0;
    pg_on <= 1'b1;
    press <= 1'b0;
    n_a <= 1'b0;
    eng_off <= 1'b0;
    eng_pg <= 1'b0;
    deep_ok <= 1'b1;
    awv <= 1'b0;
    wv <= 1'b0;
    br <= 1'b0;
    arv <= 1'b0;
    rr <= 1'b0;
    awa <= 8'h00;
    ara <= 8'h00;
    wd <= 32'h0;
    ws <= 4'hf;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (60) @(posedge clk_sys);
    chk("prst", 1, prst_n);
    chk("pullup", 1, pu);
    rd(psrc_pkg::CTRL_OFS);
    chk("ctrl", {16'h0, psrc_pkg::CTRL_RESET}, rd_val);
    rd(psrc_pkg::CMD_OFS);
    chk("cmd", 0, rd_val);
    rd(psrc_pkg::STATUS_OFS);
    chk("status", 32'h8, {28'h0, rd_val[3:0]});
    rd(8'h10, psrc_pkg::RESP_SLVERR);
    chk("unmapped", 0, rd_val);
    wr(8'h10, 32'h1, psrc_pkg::RESP_SLVERR);
    wr(psrc_pkg::STATUS_OFS, 32'hff);
    state_is(3'h0);
    pg_on <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("prst", 0, prst_n);
    pg_on <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("prst", 1, prst_n);
    push(30);
    chk("sci", 1, seen[0]);
    rd(psrc_pkg::EVENT_OFS);
    chk("ev_btn", 1, rd_val[0]);
    wr(psrc_pkg::EVENT_OFS, 32'h1);
    rd(psrc_pkg::EVENT_OFS);
    chk("ev_clr", 0, rd_val[0]);
    wr(psrc_pkg::CTRL_OFS, 32'h41);
    // two holds each under the override time, together over it
    push(70);
    push(70);
    chk("smi", 2, seen[1]);
    state_is(3'h0);
    cmd(psrc_pkg::CMD_SLEEP);
    repeat (4) @(posedge clk_sys);
    chk("prst", 0, prst_n);
    push(30);
    repeat (20) @(posedge clk_sys);
    chk("wake", 1, seen[2]);
    chk("prst", 1, prst_n);
    cmd(psrc_pkg::CMD_HIBERNATE);
    state_is(3'h2);
    n_a <= 1'b1;
    repeat (4) @(posedge clk_sys);
    n_a <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("wake", 2, seen[2]);
    state_is(3'h0);
    for (int c = 4; c <= 6; c++) begin
      cmd(3'(c));
      repeat (3) @(posedge clk_sys);
      chk("prst", 0, prst_n);
      repeat (30) @(posedge clk_sys);
      chk("prst", 1, prst_n);
    end
    wr(psrc_pkg::CTRL_OFS, 32'h0344);
    cmd(psrc_pkg::CMD_SLEEP);
    eng_off <= 1'b1;
    repeat (2) @(posedge clk_sys);
    eng_off <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("ma", 0, ma_n);
    chk("lan", 0, lan_n);
    repeat (3) @(posedge clk_sys);
    chk("ma_min", 0, ma_n);
    repeat (20) @(posedge clk_sys);
    chk("ma", 1, ma_n);
    chk("lan", 1, lan_n);
    chk("phy", 1, seen[3]);
    wr(psrc_pkg::CTRL_OFS, 32'h034c);
    eng_pg <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("vwire", 1, vw);
    chk("ma_pin", 1, ma_n);
    eng_pg <= 1'b0;
    push(30);
    repeat (20) @(posedge clk_sys);
    chk("lan_wk", 1, lan_n);
    chk("prst", 1, prst_n);
    wr(psrc_pkg::CTRL_OFS, 32'h0042);
    cmd(psrc_pkg::CMD_SOFT_OFF);
    state_is(3'h3);
    push(30);
    state_is(3'h0);
    cmd(psrc_pkg::CMD_HIBERNATE);
    push(120);
    chk("deep", 1, deep);
    chk("prst", 0, prst_n);
    rd(psrc_pkg::EVENT_OFS);
    chk("ev_ovr", 1, rd_val[2]);
    state_is(3'h4);
    n_a <= 1'b1;
    repeat (4) @(posedge clk_sys);
    n_a <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("deep", 0, deep);
    conclude();
  end
endmodule
